// >>> common/primary_status_pkg.sv
package primary_status_pkg;

  // configuration-space location of the status word (byte offset)
  localparam logic [7:0]  STATUS_OFFSET       = 8'h06;
  localparam logic [15:0] STATUS_RESET        = 16'h0010;

  // field positions inside the status word
  localparam int          POS_DETECTED_POISON = 15;
  localparam int          POS_SIGNALLED_SERR  = 14;
  localparam int          POS_RECEIVED_UR     = 13;
  localparam int          POS_RECEIVED_CA     = 12;
  localparam int          POS_SIGNALLED_CA    = 11;
  localparam int          POS_MASTER_PARITY   = 8;
  localparam int          POS_CAP_CHAIN       = 4;

  // constant fields
  localparam logic [1:0]  SELECT_TIMING_VALUE = 2'h0;
  localparam logic        BACK_TO_BACK_VALUE  = 1'b0;
  localparam logic        DOUBLE_SPEED_VALUE  = 1'b0;
  localparam logic        CAP_CHAIN_VALUE     = 1'b1;
  localparam logic        INT_PENDING_VALUE   = 1'b0;

  // sticky flag order inside the flag bank
  localparam int          FLAG_COUNT          = 6;
  localparam int          FI_MASTER_PARITY    = 0;
  localparam int          FI_SIGNALLED_CA     = 1;
  localparam int          FI_RECEIVED_CA      = 2;
  localparam int          FI_RECEIVED_UR      = 3;
  localparam int          FI_SIGNALLED_SERR   = 4;
  localparam int          FI_DETECTED_POISON  = 5;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } cfg_req_t;

  // one-cycle event pulses from the serial-link side
  typedef struct packed {
    logic rx_poisoned_tlp;
    logic rx_cpl_unsupported;
    logic rx_cpl_completer_abort;
    logic tx_cpl_completer_abort;
    logic rx_poisoned_cpl_data;
    logic rx_write_poisoned;
  } link_events_t;

  typedef enum logic [0:0] {
    MSG_IDLE,
    MSG_SEND
  } msg_state_t;

endpackage

// >>> rtl/cfg_word_port.sv
`timescale 1ns/100ps
module cfg_word_port
  import primary_status_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // configuration access
  input  wire cfg_req_t    cfg_req,
  output logic      [15:0] cfg_rdata,
  output logic             cfg_rd_valid,
  // register core side
  input  wire logic [15:0] word_value,
  output logic      [15:0] clear_mask
);

  logic        hit;
  logic [15:0] lane_mask;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;

  always_comb begin
    hit        = (cfg_req.addr == STATUS_OFFSET);
    lane_mask  = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
    // write-one-to-clear; zeros and other offsets leave flags alone
    clear_mask = (cfg_req.wr && hit) ? (cfg_req.wdata & lane_mask) : 16'h0000;
    nxt_rvalid = cfg_req.rd;
    // unmatched offsets read as zero so the caller always gets an answer
    nxt_rdata  = (cfg_req.rd && hit) ? (word_value & lane_mask) : 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign cfg_rdata    = rdata_ff;
  assign cfg_rd_valid = rvalid_ff;

endmodule

// >>> rtl/primary_link_status_flags.sv
`timescale 1ns/100ps
// Operation
// - poisoned TLP received sets bit 15 regardless of parity-response enable
// - bit 14 set on sending fatal/nonfatal message only with system-error enable
// - unsupported-request completion received sets bit 13
// - completer-abort completion received sets bit 12
// - completing a request with completer-abort status sets bit 11
// - with parity-response enable, poisoned completion data or poisoned write sets bit 8
// - select-timing field bits 10:9 always read zero
// - back-to-back bit 7 and double-speed bit 5 are constant zero
// - capability-chain bit 4 always reads one
// - interrupt-pending bit 3 always reads zero
// - reserved bit 6 and bits 2:0 read zero and store nothing
// - without system-error enable, secondary system errors are not reported upstream
// - received poisoned TLP goes to parallel bus with bad parity, always
module primary_link_status_flags
  import primary_status_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // configuration access
  input  wire cfg_req_t     cfg_req,
  output logic       [15:0] cfg_rdata,
  output logic              cfg_rd_valid,
  // command word enables held elsewhere
  input  wire logic         system_error_enable,
  input  wire logic         parity_response_enable,
  // serial-link events
  input  wire link_events_t link_events,
  // secondary-bus system error seen
  input  wire logic         sec_serr_seen,
  input  wire logic         sec_serr_fatal,
  // other sources of error messages sent upstream
  input  wire logic         other_err_msg_sent,
  // error message toward the upstream partner
  output logic              err_msg_valid,
  output logic              err_msg_fatal,
  input  wire logic         err_msg_ready,
  // poisoned data forwarding toward the parallel bus
  input  wire logic         fwd_valid,
  input  wire logic         fwd_poisoned,
  output logic              fwd_force_bad_parity,
  output logic              fwd_strobe,
  // live status word
  output logic       [15:0] status_word
);

  logic [FLAG_COUNT-1:0] flags;
  logic [FLAG_COUNT-1:0] set_pulse;
  logic [FLAG_COUNT-1:0] clr_pulse;
  logic [15:0]           clear_mask;
  logic [15:0]           word_value;

  msg_state_t            msg_state_ff;
  msg_state_t            nxt_msg_state;
  logic                  msg_fatal_ff;
  logic                  nxt_msg_fatal;
  logic                  msg_sent;

  logic                  bad_par_ff;
  logic                  nxt_bad_par;
  logic                  fwd_strobe_ff;
  logic                  nxt_fwd_strobe;

  // upstream error message sender
  always_comb begin
    nxt_msg_state = msg_state_ff;
    nxt_msg_fatal = msg_fatal_ff;
    unique case (msg_state_ff)
      MSG_IDLE: begin
        // secondary errors are only turned into messages when enabled
        if (sec_serr_seen && system_error_enable) begin
          nxt_msg_state = MSG_SEND;
          nxt_msg_fatal = sec_serr_fatal;
        end
      end
      MSG_SEND: begin
        if (err_msg_ready) begin
          nxt_msg_state = MSG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      msg_state_ff <= MSG_IDLE;
      msg_fatal_ff <= 1'b0;
    end else begin
      msg_state_ff <= nxt_msg_state;
      msg_fatal_ff <= nxt_msg_fatal;
    end
  end

  assign err_msg_valid = (msg_state_ff == MSG_SEND);
  assign err_msg_fatal = msg_fatal_ff;
  assign msg_sent      = (err_msg_valid && err_msg_ready) || other_err_msg_sent;

  // poisoned forwarding; parity-response enable plays no part here
  always_comb begin
    nxt_fwd_strobe = fwd_valid;
    nxt_bad_par    = fwd_valid && fwd_poisoned;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bad_par_ff    <= 1'b0;
      fwd_strobe_ff <= 1'b0;
    end else begin
      bad_par_ff    <= nxt_bad_par;
      fwd_strobe_ff <= nxt_fwd_strobe;
    end
  end

  assign fwd_force_bad_parity = bad_par_ff;
  assign fwd_strobe           = fwd_strobe_ff;

  // event qualification into flag set pulses
  always_comb begin
    set_pulse                     = '0;
    set_pulse[FI_DETECTED_POISON] = link_events.rx_poisoned_tlp;
    // a message sent while disabled leaves the flag clear
    set_pulse[FI_SIGNALLED_SERR]  = msg_sent && system_error_enable;
    set_pulse[FI_RECEIVED_UR]     = link_events.rx_cpl_unsupported;
    set_pulse[FI_RECEIVED_CA]     = link_events.rx_cpl_completer_abort;
    set_pulse[FI_SIGNALLED_CA]    = link_events.tx_cpl_completer_abort;
    set_pulse[FI_MASTER_PARITY]   = parity_response_enable &&
                                    (link_events.rx_poisoned_cpl_data ||
                                     link_events.rx_write_poisoned);
  end

  always_comb begin
    clr_pulse                     = '0;
    clr_pulse[FI_DETECTED_POISON] = clear_mask[POS_DETECTED_POISON];
    clr_pulse[FI_SIGNALLED_SERR]  = clear_mask[POS_SIGNALLED_SERR];
    clr_pulse[FI_RECEIVED_UR]     = clear_mask[POS_RECEIVED_UR];
    clr_pulse[FI_RECEIVED_CA]     = clear_mask[POS_RECEIVED_CA];
    clr_pulse[FI_SIGNALLED_CA]    = clear_mask[POS_SIGNALLED_CA];
    clr_pulse[FI_MASTER_PARITY]   = clear_mask[POS_MASTER_PARITY];
  end

  rw1c_flag_bank #(
    .N         (FLAG_COUNT)
  ) u_flags (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .set_pulse (set_pulse),
    .clr_pulse (clr_pulse),
    .flags     (flags)
  );

  // status word assembly; everything but the flags is wired constant
  always_comb begin
    word_value                      = 16'h0000;
    word_value[POS_DETECTED_POISON] = flags[FI_DETECTED_POISON];
    word_value[POS_SIGNALLED_SERR]  = flags[FI_SIGNALLED_SERR];
    word_value[POS_RECEIVED_UR]     = flags[FI_RECEIVED_UR];
    word_value[POS_RECEIVED_CA]     = flags[FI_RECEIVED_CA];
    word_value[POS_SIGNALLED_CA]    = flags[FI_SIGNALLED_CA];
    word_value[10:9]                = SELECT_TIMING_VALUE;
    word_value[POS_MASTER_PARITY]   = flags[FI_MASTER_PARITY];
    word_value[7]                   = BACK_TO_BACK_VALUE;
    word_value[5]                   = DOUBLE_SPEED_VALUE;
    word_value[POS_CAP_CHAIN]       = CAP_CHAIN_VALUE;
    word_value[3]                   = INT_PENDING_VALUE;
  end

  assign status_word = word_value;

  cfg_word_port u_port (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .cfg_req      (cfg_req),
    .cfg_rdata    (cfg_rdata),
    .cfg_rd_valid (cfg_rd_valid),
    .word_value   (word_value),
    .clear_mask   (clear_mask)
  );

endmodule

// >>> rtl/rw1c_flag_bank.sv
`timescale 1ns/100ps
module rw1c_flag_bank
  import primary_status_pkg::*;
#(
  parameter int N = FLAG_COUNT
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // hardware set and software clear
  input  wire logic [N-1:0] set_pulse,
  input  wire logic [N-1:0] clr_pulse,
  // flag state
  output logic      [N-1:0] flags
);

  if (N < 1) begin : g_bad_n
    $error("rw1c_flag_bank needs at least one flag");
  end

  logic [N-1:0] flag_ff;
  logic [N-1:0] nxt_flag;

  for (genvar i = 0; i < N; i++) begin : g_flag
    // a set in the clearing cycle is kept so no event is lost
    always_comb begin
      nxt_flag[i] = set_pulse[i] | (flag_ff[i] & ~clr_pulse[i]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flags = flag_ff;

endmodule

// >>> verif/primary_link_status_flags_properties.sv
`timescale 1ns/100ps
module primary_link_status_flags_properties
  import primary_status_pkg::*;
(
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  // observed ports
  input wire cfg_req_t     cfg_req,
  input wire logic         cfg_rd_valid,
  input wire logic         system_error_enable,
  input wire logic         parity_response_enable,
  input wire link_events_t link_events,
  input wire logic         sec_serr_seen,
  input wire logic         err_msg_valid,
  input wire logic         fwd_valid,
  input wire logic         fwd_poisoned,
  input wire logic         fwd_force_bad_parity,
  input wire logic         fwd_strobe,
  input wire logic  [15:0] status_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic clr_top;
  assign clr_top = cfg_req.wr && cfg_req.addr == STATUS_OFFSET && cfg_req.be[1]
                   && cfg_req.wdata[15];
  chk_poison_set: assert property (link_events.rx_poisoned_tlp |=> status_word[15])
    else $error("poison flag not set");
  chk_serr_gate: assert property ($rose(status_word[14]) |-> $past(system_error_enable))
    else $error("system error flag set while disabled");
  chk_ur_set: assert property (link_events.rx_cpl_unsupported |=> status_word[13])
    else $error("unsupported flag not set");
  chk_ca_rx_set: assert property (link_events.rx_cpl_completer_abort |=> status_word[12])
    else $error("received abort flag not set");
  chk_ca_tx_set: assert property (link_events.tx_cpl_completer_abort |=> status_word[11])
    else $error("signalled abort flag not set");
  chk_parity_gate: assert property ((link_events.rx_poisoned_cpl_data
    || link_events.rx_write_poisoned) && parity_response_enable |=> status_word[8])
    else $error("data parity flag not set");
  chk_timing_zero: assert property (status_word[10:9] == 2'h0)
    else $error("select timing not zero");
  chk_const_low: assert property (status_word[7:0] == 8'h10)
    else $error("constant bits wrong");
  chk_serr_silent: assert property (!system_error_enable && sec_serr_seen
    && !err_msg_valid |=> !err_msg_valid)
    else $error("message sent while disabled");
  chk_bad_parity: assert property (fwd_valid && fwd_poisoned |=> fwd_force_bad_parity && fwd_strobe)
    else $error("poisoned beat not forced bad");
  chk_flag_sticky: assert property (status_word[15] && !clr_top |=> status_word[15])
    else $error("flag lost without clear");
  chk_rd_latency: assert property (cfg_req.rd |=> cfg_rd_valid)
    else $error("read not answered");
  cover property (status_word[15] && clr_top ##1 !status_word[15]);
  cover property ($rose(err_msg_valid));
  cover property (fwd_force_bad_parity);
endmodule

// >>> verif/primary_link_status_flags_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module primary_link_status_flags_tb_top;
  import primary_status_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  cfg_req_t    cfg_req = '0;
  logic        system_error_enable = 1'b0;
  logic        parity_response_enable = 1'b0;
  logic [9:0]  ev = '0;
  logic        fatal = 1'b0;
  logic [2:0]  delay = 3'h0;
  logic [15:0] cfg_rdata, status_word, exp;
  logic        cfg_rd_valid, err_msg_valid, err_msg_fatal, err_msg_ready;
  logic        fwd_force_bad_parity, fwd_strobe, last_fatal;
  logic [7:0]  msg_count;
  int          n_errors = 0;
  int          cmp_count = 0;
  localparam int POS [6] = '{15, 13, 12, 11, 8, 8};
  always #4 clk_sys = ~clk_sys;
  primary_link_status_flags dut_u (.clk_sys, .sys_rst, .cfg_req, .cfg_rdata, .cfg_rd_valid,
    .system_error_enable, .parity_response_enable, .link_events(link_events_t'(ev[9:4])),
    .sec_serr_seen(ev[3]), .sec_serr_fatal(fatal), .other_err_msg_sent(ev[2]),
    .err_msg_valid, .err_msg_fatal, .err_msg_ready, .fwd_valid(ev[1]), .fwd_poisoned(ev[0]),
    .fwd_force_bad_parity, .fwd_strobe, .status_word);
  upstream_msg_sink sink_u (.clk_sys, .sys_rst, .err_msg_valid, .err_msg_fatal,
    .err_msg_ready, .delay, .msg_count, .last_fatal);
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cfg_rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    #1 cfg_req = '{1'b0, 1'b1, a, 2'h3, 16'h0000};
    @(posedge clk_sys);
    #1 cfg_req = '0;
    `CHK("read valid", 1'b1, cfg_rd_valid)
    `CHK("read data", e, cfg_rdata)
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge clk_sys);
    #1 cfg_req = '{1'b1, 1'b0, a, b, d};
    @(posedge clk_sys);
    #1 cfg_req = '0;
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge clk_sys);
    #1 ev = v;
    @(posedge clk_sys);
    #1 ev = '0;
  endtask
  task automatic wait_msg(input logic [7:0] n);
    for (int k = 0; k < 20 && msg_count !== n; k++) @(posedge clk_sys);
    #1 `CHK("msg count", n, msg_count)
  endtask
  initial begin
    #40000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    cfg_rd(STATUS_OFFSET, STATUS_RESET);
    cfg_wr(STATUS_OFFSET, 2'h3, 16'hffff);
    cfg_rd(STATUS_OFFSET, STATUS_RESET);
    cfg_rd(8'h08, 16'h0000);
    // every link event with the parity enable off, then on
    for (int p = 0; p < 2; p++) begin
      parity_response_enable = p[0];
      for (int i = 0; i < 6; i++) begin
        exp = STATUS_RESET | ((POS[i] == 8 && p == 0) ? 16'h0000 : 16'h0001 << POS[i]);
        pulse(10'h200 >> i);
        cfg_wr(8'h08, 2'h3, 16'hffff);
        cfg_wr(STATUS_OFFSET, 2'h1, 16'hffff);
        cfg_wr(STATUS_OFFSET, 2'h3, ~(16'h0001 << POS[i]));
        cfg_rd(STATUS_OFFSET, exp);
        cfg_wr(STATUS_OFFSET, 2'h2, 16'h0001 << POS[i]);
        cfg_rd(STATUS_OFFSET, STATUS_RESET);
      end
    end
    fatal = 1'b1;
    pulse(10'h008);
    pulse(10'h004);
    wait_msg(8'h00);
    cfg_rd(STATUS_OFFSET, STATUS_RESET);
    system_error_enable = 1'b1;
    delay = 3'h3;
    pulse(10'h008);
    wait_msg(8'h01);
    `CHK("msg fatal", 1'b1, last_fatal)
    cfg_rd(STATUS_OFFSET, 16'h4010);
    cfg_wr(STATUS_OFFSET, 2'h2, 16'h4000);
    fatal = 1'b0;
    delay = 3'h0;
    pulse(10'h008);
    wait_msg(8'h02);
    `CHK("msg fatal", 1'b0, last_fatal)
    cfg_wr(STATUS_OFFSET, 2'h2, 16'h4000);
    pulse(10'h004);
    cfg_rd(STATUS_OFFSET, 16'h4010);
    parity_response_enable = 1'b0;
    pulse(10'h003);
    `CHK("bad parity", 1'b1, fwd_force_bad_parity)
    `CHK("fwd strobe", 1'b1, fwd_strobe)
    pulse(10'h002);
    `CHK("bad parity", 1'b0, fwd_force_bad_parity)
    // a reset in mid-run drops every flag
    pulse(10'h200);
    @(posedge clk_sys);
    #1 sys_rst = 1'b1;
    @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    cfg_rd(STATUS_OFFSET, STATUS_RESET);
    complete_run;
  end
endmodule
bind primary_link_status_flags primary_link_status_flags_properties chk_u (.clk_sys, .sys_rst,
  .cfg_req, .cfg_rd_valid, .system_error_enable, .parity_response_enable, .link_events,
  .sec_serr_seen, .err_msg_valid, .fwd_valid, .fwd_poisoned, .fwd_force_bad_parity,
  .fwd_strobe, .status_word);

// >>> verif/upstream_msg_sink.sv
`timescale 1ns/100ps
module upstream_msg_sink (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // message handshake
  input  wire logic       err_msg_valid,
  input  wire logic       err_msg_fatal,
  output logic            err_msg_ready,
  // pacing and record
  input  wire logic [2:0] delay,
  output logic      [7:0] msg_count,
  output logic            last_fatal
);
  logic [2:0] wait_ff;
  // ready only after the chosen stall, never offered while idle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      {err_msg_ready, wait_ff, msg_count, last_fatal} <= '0;
    end else if (err_msg_valid && err_msg_ready) begin
      err_msg_ready <= 1'b0;
      wait_ff       <= 3'h0;
      msg_count     <= msg_count + 8'h01;
      last_fatal    <= err_msg_fatal;
    end else if (err_msg_valid) begin
      wait_ff       <= wait_ff + 3'h1;
      err_msg_ready <= (wait_ff >= delay);
    end
  end
endmodule
